// ---- common/hsp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface hsp_if;
  logic scl;        // serial clock, made by the host
  logic ss;         // shared select pin
  logic sda_h_o;    // host data out level
  logic sda_h_oe_n; // host pulls data low when low
  logic sda_d_o;    // device data out level
  logic sda_d_oe_n; // device pulls data low when low
  logic irq_n;      // interrupt request output, low active
  wire logic sda;   // resolved open-drain data line

  // wired-and with pull-up
  assign sda = ((~sda_h_oe_n & ~sda_h_o) | (~sda_d_oe_n & ~sda_d_o)) ? 1'b0 : 1'b1;

  modport dev (input scl, ss, sda, output sda_d_o, sda_d_oe_n, irq_n);
  modport host (output scl, ss, sda_h_o, sda_h_oe_n, input sda, irq_n);
endinterface
`default_nettype wire

// ---- common/hsp_pkg.sv ----
`default_nettype none
package hsp_pkg;
  // ****************************************
  // bus identity and operation codes
  // ****************************************
  localparam logic [6:0] I2C_ADDR7 = 7'h38;
  localparam logic [7:0] ADDR_WR = {I2C_ADDR7, 1'b0};
  localparam logic [7:0] ADDR_RD = {I2C_ADDR7, 1'b1};
  localparam logic [7:0] OP_WRITE = 8'hCA;
  localparam logic [7:0] OP_READ = 8'h35;
  localparam logic [1:0] SEL_LAST = 2'h2;
  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [15:0] A_LAST_D32 = 16'hE5FF;
  localparam logic [15:0] A_LAST_D8 = 16'hE7FD;
  localparam logic [15:0] A_LAST_ADDR = 16'hE9FE;
  localparam logic [15:0] A_LAST_D16 = 16'hE9FF;
  localparam logic [15:0] A_LAST_OPERATION_KIND = 16'hEA01;
  localparam logic [15:0] A_FLAG = 16'hE500;
  localparam logic [15:0] A_MASK = 16'hE504;
  localparam logic [15:0] A_CFG2 = 16'hEC10;
  localparam int CFG2_HSC = 0;
  localparam int CFG2_LOCK = 1;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  localparam logic [31:0] REC_RST = 32'h00000000;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_MAX_KHZ = 400;
  // least quarter period of scl, rounded up to whole clocks
  localparam int SCL_QTR_CYC =
    (1000000 / SCL_MAX_KHZ + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // access width in bytes of a register offset
  function automatic logic [2:0] reg_bytes(input logic [15:0] a);
    if (a == A_LAST_D32 || a == A_FLAG || a == A_MASK)
      return 3'h4;
    else if (a == A_LAST_ADDR || a == A_LAST_D16)
      return 3'h2;
    else
      return 3'h1;
  endfunction

  // offsets of the last-access records
  function automatic logic is_record(input logic [15:0] a);
    return a == A_LAST_D32 || a == A_LAST_D8 || a == A_LAST_ADDR ||
           a == A_LAST_D16 || a == A_LAST_OPERATION_KIND;
  endfunction
endpackage
`default_nettype wire

// ---- core/hsp_dev.sv ----
// Overview of operation
// - select high after reset keeps two-wire port
// - three select falls switch to four-wire port
// - capture port disabled out of reset
// - host toggles select or writes spare address; only the select toggle is built here
// - lock bit freezes two-wire port choice
// - four-wire config write locks the port
// - lock survives reset outside normal mode; normal-mode reset and power-down clear
// - successful access stores sixteen-bit address
// - last operation code marks write or read
// - last data kept per access width
// - failed transfers leave records unchanged
// - reading records never updates records
// - open-drain hardware slave up to 400 kHz
// - fixed seven-bit address, write byte 0x70
// - address, pointer, data; every byte acknowledged
// - most significant bit first everywhere
// - read uses pointer stage, repeated start
// - master acks all but last, then stops
// - status read then written back clears
// - host reads linked register before clearing
// - host uses falling-edge interrupt input
// - only four-wire alone or two-wire plus capture
// - flags clear by one, request low until clear
`timescale 1ns/1ps
`default_nettype none
module hsp_dev
  import hsp_pkg::*;
(
  input wire logic clock,             // device clock
  input wire logic srst,              // synchronous reset, high
  input wire logic normal_power_mode, // high while in normal power mode
  input wire logic power_down,        // power-down, clears the port choice
  input wire logic [31:0] event_in,   // interrupt events, one-cycle pulses
  input wire logic spi_cfg2_write,    // four-wire engine wrote config register
  output logic spi_mode,              // four-wire port selected
  output logic port_locked,           // port choice locked
  output logic hsc_enable,            // high-speed capture port enable
  hsp_if.dev lnk                      // serial link
);
  typedef enum {D_IDLE, D_ADDR, D_PTRH, D_PTRL, D_WDAT, D_RDAT, D_SKIP} hsp_dst_t;

  hsp_dst_t st;
  hsp_dst_t next_st;
  logic lnk_bit;
  logic [2:0] pin_s;
  logic [2:0] pin_d;
  logic [3:0] bcnt;
  logic [7:0] sh;
  logic [15:0] ptr;
  logic [31:0] wdat;
  logic [2:0] nb;
  logic rd_nack;
  logic [31:0] tx;
  logic [31:0] rval;
  logic drv;
  logic [31:0] flag;
  logic [31:0] mask;
  logic [7:0] cfg2;
  logic [15:0] last_addr;
  logic [7:0] last_operation_kind;
  logic [7:0] last_d8;
  logic [15:0] last_d16;
  logic [31:0] last_d32;
  logic [1:0] sel_cnt;
  logic irq_q;

  // ****************************************
  // link clock domain
  // ****************************************
  // data bit caught on the serial clock; it holds a whole scl period,
  // far longer than the synchroniser delay that qualifies its use
  always_ff @(posedge lnk.scl)
  begin
    lnk_bit <= lnk.sda;
  end

  // ****************************************
  // pin sampling and bus conditions
  // ****************************************
  hsp_sync #(.W(3), .INIT(3'h7)) u_sync (
    .clock(clock),
    .srst(srst),
    .d({lnk.ss, lnk.sda, lnk.scl}),
    .q(pin_s)
  );

  always_ff @(posedge clock)
  begin
    if (srst)
      pin_d <= 3'h7;
    else
      pin_d <= pin_s;
  end

  // scl edges, start and stop conditions, select falls
  wire scl_s = pin_s[0];
  wire sda_s = pin_s[1];
  wire rise = scl_s & ~pin_d[0];
  wire fall = ~scl_s & pin_d[0];
  wire start_c = scl_s & pin_d[0] & pin_d[1] & ~sda_s;
  wire stop_c = scl_s & pin_d[0] & ~pin_d[1] & sda_s;
  wire ss_fall = pin_d[2] & ~pin_s[2];
  wire i2c_on = ~spi_mode;
  wire ack_slot = rise & (bcnt == 4'h8);
  wire [2:0] width = reg_bytes(ptr);

  // ****************************************
  // register read selection
  // ****************************************
  wire [31:0] reg_val =
    (ptr == A_FLAG) ? flag :
    (ptr == A_MASK) ? mask :
    (ptr == A_CFG2) ? {24'h000000, cfg2} :
    (ptr == A_LAST_ADDR) ? {16'h0000, last_addr} :
    (ptr == A_LAST_OPERATION_KIND) ? {24'h000000, last_operation_kind} :
    (ptr == A_LAST_D8) ? {24'h000000, last_d8} :
    (ptr == A_LAST_D16) ? {16'h0000, last_d16} :
    (ptr == A_LAST_D32) ? last_d32 : 32'h00000000;
  // first byte to send sits in the top lane
  wire [31:0] tx_load = (width == 3'h1) ? {reg_val[7:0], 24'h000000} :
                        (width == 3'h2) ? {reg_val[15:0], 16'h0000} : reg_val;
  wire [7:0] tx_hi = tx[31:24];
  wire tx_bit = tx_hi[3'h7 - bcnt[2:0]];
  // every byte of ours is acknowledged; foreign addresses are not
  wire ack_now = (st == D_ADDR) ? (sh == ADDR_WR || sh == ADDR_RD) :
                 (st == D_PTRH || st == D_PTRL || st == D_WDAT);

  // ****************************************
  // transfer state
  // ****************************************
  // next state, taken on the acknowledge bit
  always_comb
  begin
    next_st = st;
    case (st)
      D_ADDR: next_st = (sh == ADDR_WR) ? D_PTRH : (sh == ADDR_RD) ? D_RDAT : D_SKIP;
      D_PTRH: next_st = D_PTRL;
      D_PTRL: next_st = D_WDAT;
      default: next_st = st;
    endcase
  end

  // a start, repeated or not, reopens the address phase while the two-wire port is on
  always_ff @(posedge clock)
  begin
    if (srst | stop_c | ~i2c_on)
      st <= D_IDLE;
    else if (start_c)
      st <= D_ADDR;
    else if (ack_slot)
      st <= next_st;
  end

  // bit counter: eight data bits, then the acknowledge bit
  always_ff @(posedge clock)
  begin
    if (srst | start_c | stop_c)
      bcnt <= 4'h0;
    else if (rise)
      bcnt <= (bcnt == 4'h8) ? 4'h0 : bcnt + 4'h1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      sh <= 8'h00;
    else if (rise && bcnt != 4'h8)
      sh <= {sh[6:0], lnk_bit};
  end

  // pointer is never cleared by a start, so the read stage finds it
  always_ff @(posedge clock)
  begin
    if (srst)
      ptr <= 16'h0000;
    else if (ack_slot && st == D_PTRH)
      ptr[15:8] <= sh;
    else if (ack_slot && st == D_PTRL)
      ptr[7:0] <= sh;
  end

  always_ff @(posedge clock)
  begin
    if (srst | start_c)
      wdat <= 32'h00000000;
    else if (ack_slot && st == D_WDAT)
      wdat <= {wdat[23:0], sh};
  end

  // byte count saturates so an overlong transfer never matches a width
  always_ff @(posedge clock)
  begin
    if (srst | start_c)
      nb <= 3'h0;
    else if (ack_slot && (st == D_WDAT || st == D_RDAT) && nb != 3'h7)
      nb <= nb + 3'h1;
  end

  // master leaves the last read byte unacknowledged
  always_ff @(posedge clock)
  begin
    if (srst | start_c)
      rd_nack <= 1'b0;
    else if (ack_slot && st == D_RDAT && lnk_bit)
      rd_nack <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tx <= 32'h00000000;
      rval <= 32'h00000000;
    end
    else if (ack_slot && st == D_ADDR && sh == ADDR_RD)
    begin
      tx <= tx_load;
      rval <= reg_val;
    end
    else if (ack_slot && st == D_RDAT)
      tx <= {tx[23:0], 8'h00};
  end

  // data line only changes after scl has fallen
  always_ff @(posedge clock)
  begin
    if (srst | start_c | stop_c | ~i2c_on)
      drv <= 1'b0;
    else if (fall && bcnt == 4'h8)
      drv <= ack_now;
    else if (fall)
      drv <= st == D_RDAT && !rd_nack && nb < width && !tx_bit;
  end

  assign lnk.sda_d_o = 1'b0;
  assign lnk.sda_d_oe_n = ~drv;

  // ****************************************
  // completion and last-access records
  // ****************************************
  // only a frame stopped right after a full, matching transfer counts
  wire wr_ok = stop_c && st == D_WDAT && bcnt == 4'h1 && nb == width;
  wire rd_ok = stop_c && st == D_RDAT && rd_nack && nb == width;
  wire rd_rec = rd_ok && !is_record(ptr);
  wire [31:0] acc_data = wr_ok ? wdat : rval;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      last_addr <= REC_RST[15:0];
      last_operation_kind <= REC_RST[7:0];
    end
    else if (wr_ok | rd_rec)
    begin
      last_addr <= ptr;
      last_operation_kind <= wr_ok ? OP_WRITE : OP_READ;
    end
  end

  // data lands in the record of the access width
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      last_d8 <= REC_RST[7:0];
      last_d16 <= REC_RST[15:0];
      last_d32 <= REC_RST;
    end
    else if ((wr_ok | rd_rec) && width == 3'h1)
      last_d8 <= acc_data[7:0];
    else if ((wr_ok | rd_rec) && width == 3'h2)
      last_d16 <= acc_data[15:0];
    else if (wr_ok | rd_rec)
      last_d32 <= acc_data;
  end

  // ****************************************
  // control and interrupt registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mask <= MASK_RST;
      cfg2 <= CFG2_RST;
    end
    else if (wr_ok && ptr == A_MASK)
      mask <= wdat;
    else if (wr_ok && ptr == A_CFG2)
      cfg2 <= wdat[7:0];
  end

  // write-one-to-clear; a new event in the same cycle wins
  wire [31:0] flag_clr = (wr_ok && ptr == A_FLAG) ? wdat : 32'h00000000;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      flag <= 32'h00000000;
      irq_q <= 1'b0;
    end
    else
    begin
      flag <= (flag & ~flag_clr) | event_in;
      irq_q <= |(flag & mask);
    end
  end

  assign lnk.irq_n = ~irq_q;

  // capture port only alongside the two-wire port
  always_ff @(posedge clock)
  begin
    if (srst)
      hsc_enable <= 1'b0;
    else
      hsc_enable <= cfg2[CFG2_HSC] & ~spi_mode;
  end

  // ****************************************
  // port choice
  // ****************************************
  // kept through a reset outside normal mode; power-down always clears
  wire mode_clr = (srst & normal_power_mode) | power_down;
  wire lock_set = (wr_ok && ptr == A_CFG2 && wdat[CFG2_LOCK] && !spi_mode) ||
                  (spi_cfg2_write && spi_mode);
  wire sel_step = ss_fall & ~port_locked & ~spi_mode;

  always_ff @(posedge clock)
  begin
    if (mode_clr)
    begin
      sel_cnt <= 2'h0;
      spi_mode <= 1'b0;
      port_locked <= 1'b0;
    end
    else
    begin
      if (sel_step)
        sel_cnt <= sel_cnt + 2'h1;
      if (sel_step && sel_cnt == SEL_LAST)
        spi_mode <= 1'b1;
      if (lock_set)
        port_locked <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- core/hsp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module hsp_host
  import hsp_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYC  // clocks per quarter scl period
)
(
  input wire logic clock,           // host clock
  input wire logic srst,            // synchronous reset, high
  input wire logic cmd_valid,       // transfer request
  output logic cmd_ready,           // request taken when valid
  input wire logic cmd_read,        // 1 read, 0 write
  input wire logic [15:0] cmd_addr, // register address
  input wire logic [2:0] cmd_bytes, // 1, 2 or 4
  input wire logic [31:0] cmd_wdata,// write data, low bytes used
  input wire logic sel_spi,         // toggle the select pin six times: three falls
  output logic done,                // one-cycle pulse at the end
  output logic nack_err,            // a sent byte was not acknowledged
  output logic [31:0] rdata,        // read data, right-aligned
  output logic irq_fall,            // pulse on falling interrupt line
  hsp_if.host lnk                   // serial link
);
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP, H_SEL} hsp_hst_t;

  hsp_hst_t st;
  logic [$clog2(QTR)-1:0] qc;
  logic [1:0] q;
  logic [3:0] bi;
  logic [55:0] txq;
  logic [2:0] left;
  logic [2:0] rleft;
  logic rd_q;
  logic rep;
  logic rd_ph;
  logic [31:0] rsh;
  logic sda_v;
  logic scl_q;
  logic ss_q;
  logic [2:0] tog;
  logic [1:0] in_s;
  logic irq_d;

  if (QTR < 4)
  begin : g_chk
    $error("hsp_host: QTR too short for the device sampling");
  end

  hsp_sync #(.W(2), .INIT(2'h3)) u_sync (
    .clock(clock),
    .srst(srst),
    .d({lnk.irq_n, lnk.sda}),
    .q(in_s)
  );

  // ****************************************
  // slot timing
  // ****************************************
  wire tick = qc == ($clog2(QTR))'(QTR - 1);
  wire slot_end = tick && q == 2'h3;
  wire [7:0] cur = txq[55:48];
  wire [31:0] walign = (cmd_bytes == 3'h1) ? {cmd_wdata[7:0], 24'h000000} :
                       (cmd_bytes == 3'h2) ? {cmd_wdata[15:0], 16'h0000} : cmd_wdata;
  // data level for the current bit slot
  wire bit_v = rd_ph ? (bi == 4'h8 ? rleft == 3'h1 : 1'b1) :
                       (bi == 4'h8 ? 1'b1 : cur[3'h7 - bi[2:0]]);
  wire first_v = (st == H_START) ? 1'b1 : (st == H_STOP) ? 1'b0 : bit_v;

  assign cmd_ready = st == H_IDLE && !sel_spi;

  always_ff @(posedge clock)
  begin
    if (srst || st == H_IDLE || tick)
      qc <= '0;
    else
      qc <= qc + 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst || st == H_IDLE)
      q <= 2'h0;
    else if (tick)
      q <= q + 2'h1;
  end

  // scl high in quarters two and three; sda moves only while scl is low
  // except for the start and stop edges in quarter three
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      scl_q <= 1'b1;
      sda_v <= 1'b1;
    end
    else
    begin
      scl_q <= (st == H_IDLE || st == H_SEL) ? 1'b1 : q[1];
      if (st == H_IDLE)
        sda_v <= 1'b1;
      else if (tick && q == 2'h0)
        sda_v <= first_v;
      else if (tick && q == 2'h2 && st == H_START)
        sda_v <= 1'b0;
      else if (tick && q == 2'h2 && st == H_STOP)
        sda_v <= 1'b1;
    end
  end

  assign lnk.scl = scl_q;
  assign lnk.sda_h_o = 1'b0;
  assign lnk.sda_h_oe_n = sda_v;
  assign lnk.ss = ss_q;

  // ****************************************
  // frame sequencing
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (srst)
      st <= H_IDLE;
    else
      case (st)
        H_IDLE: st <= sel_spi ? H_SEL : cmd_valid ? H_START : H_IDLE;
        H_START: st <= slot_end ? H_BIT : H_START;
        H_BIT: if (slot_end && bi == 4'h8)
          st <= rd_ph ? (rleft == 3'h1 ? H_STOP : H_BIT) :
                in_s[0] ? H_STOP :
                left != 3'h1 ? H_BIT :
                (rd_q && !rep) ? H_START : rd_q ? H_BIT : H_STOP;
        H_STOP: st <= slot_end ? H_IDLE : H_STOP;
        H_SEL: st <= (tick && tog == 3'h5) ? H_IDLE : H_SEL;
        default: st <= H_IDLE;
      endcase
  end

  // byte queue: address byte, pointer, then write data
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      txq <= '0;
      left <= 3'h0;
      rleft <= 3'h0;
      rd_q <= 1'b0;
      rep <= 1'b0;
      rd_ph <= 1'b0;
      bi <= 4'h0;
    end
    else if (st == H_IDLE && cmd_valid && !sel_spi)
    begin
      txq <= {ADDR_WR, cmd_addr, walign};
      left <= cmd_read ? 3'h3 : 3'h3 + cmd_bytes;
      rleft <= cmd_bytes;
      rd_q <= cmd_read;
      rep <= 1'b0;
      rd_ph <= 1'b0;
      bi <= 4'h0;
    end
    else if (slot_end && st == H_BIT && bi != 4'h8)
      bi <= bi + 4'h1;
    else if (slot_end && st == H_BIT)
    begin
      bi <= 4'h0;
      if (rd_ph)
        rleft <= rleft - 3'h1;
      else if (left == 3'h1 && rd_q && !rep)
      begin
        txq <= {ADDR_RD, 48'h000000000000};
        left <= 3'h1;
        rep <= 1'b1;
      end
      else
      begin
        txq <= {txq[47:0], 8'h00};
        left <= left - 3'h1;
        rd_ph <= left == 3'h1 && rd_q;
      end
    end
  end

  // sampling at the end of the high half
  always_ff @(posedge clock)
  begin
    if (srst || (st == H_IDLE && cmd_valid && !sel_spi))
    begin
      rsh <= 32'h00000000;
      nack_err <= 1'b0;
    end
    else if (slot_end && st == H_BIT && rd_ph && bi != 4'h8)
      rsh <= {rsh[30:0], in_s[0]};
    else if (slot_end && st == H_BIT && !rd_ph && bi == 4'h8 && in_s[0])
      nack_err <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      done <= 1'b0;
      rdata <= 32'h00000000;
    end
    else
    begin
      done <= (slot_end && st == H_STOP) || (tick && st == H_SEL && tog == 3'h5);
      if (slot_end && st == H_STOP && rd_q)
        rdata <= rsh;
    end
  end

  // select pin driven as a plain output: three falls
  always_ff @(posedge clock)
  begin
    if (srst || st == H_IDLE)
    begin
      ss_q <= 1'b1;
      tog <= 3'h0;
    end
    else if (st == H_SEL && tick)
    begin
      ss_q <= ~ss_q;
      tog <= tog + 3'h1;
    end
  end

  // falling edge of the interrupt line, so nothing is missed while serving
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_d <= 1'b1;
      irq_fall <= 1'b0;
    end
    else
    begin
      irq_d <= in_s[1];
      irq_fall <= irq_d & ~in_s[1];
    end
  end
endmodule
`default_nettype wire

// ---- core/hsp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module hsp_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clock,        // destination clock
  input wire logic srst,         // synchronous reset
  input wire logic [W-1:0] d,    // asynchronous inputs
  output logic [W-1:0] q         // filtered, synchronised
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  if (W < 1)
  begin : g_chk
    $error("hsp_sync: W must be at least 1");
  end

  // three stages; a bit moves only when stages two and three agree
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s2 & s3) | (q & (s2 ^ s3));
    end
  end
endmodule
`default_nettype wire

// ---- test/hsp_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// link checker
// ****************
module hsp_chk
(
  input wire logic clock,      // shared clock
  input wire logic srst,       // sync reset, high
  input wire logic scl,        // serial clock
  input wire logic ss,         // shared select pin
  input wire logic sda_h_o,    // host data level
  input wire logic sda_h_oe_n, // host pulls when low
  input wire logic sda_d_o,    // device data level
  input wire logic sda_d_oe_n, // device pulls when low
  input wire logic irq_n,      // interrupt request line
  input wire logic sda         // resolved data line
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // open drain: a driver may only pull the line low
  AST_DEV_OD: assert property (!sda_d_oe_n |-> !sda_d_o)
    else $error("device drives sda high");
  AST_HOST_OD: assert property (!sda_h_oe_n |-> !sda_h_o)
    else $error("host drives sda high");
  // device data may move only while scl is low, else it would fake a start or stop
  AST_DEV_SDA_LOW: assert property ($changed(sda_d_oe_n) |-> !scl)
    else $error("device changed sda with scl high");
  AST_START_HOLD: assert property ($fell(sda) && scl |=> scl [*3])
    else $error("scl fell right after start");
  AST_STOP_HOLD: assert property ($rose(sda) && scl |=> scl [*3])
    else $error("scl fell right after stop");
  // each scl level must hold nine clocks from its edge, well short of a 400 kHz quarter
  AST_SCL_HIGH: assert property ($rose(scl) |=> scl [*8])
    else $error("scl high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |=> !scl [*8])
    else $error("scl low phase too short");
  AST_RST_IDLE: assert property ($fell(srst) |-> scl && ss && sda && irq_n)
    else $error("link not idle out of reset");
  // main scenarios
  cover property ($fell(sda) && scl);
  cover property (!sda_d_oe_n && scl);
  cover property ($fell(irq_n));
  cover property ($fell(ss));
endmodule
`default_nettype wire

// ---- test/test_host_serial_port_select_and_i2c_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_host_serial_port_select_and_i2c_slave
  import hsp_pkg::*;
;
  logic clock = 1'b0, srst = 1'b1, npm = 1'b1, pdn = 1'b0, cfg_wr = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, sel_spi = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [2:0] cmd_bytes = 3'h1;
  logic [31:0] cmd_wdata = 32'h00000000, event_in = 32'h00000000, m;
  logic spi_mode, port_locked, hsc_enable, cmd_ready, done, nack_err, irq_fall;
  logic [31:0] rdata;
  int n_mismatch = 0, total_checks = 0, cyc = 0, k, n_fall = 0;
  hsp_if lnk();
  // ****************
  // both ends and checker
  // ****************
  hsp_dev u_hsp_dev (.clock(clock), .srst(srst), .normal_power_mode(npm), .power_down(pdn),
    .event_in(event_in), .spi_cfg2_write(cfg_wr), .spi_mode(spi_mode),
    .port_locked(port_locked), .hsc_enable(hsc_enable), .lnk(lnk));
  // short quarter keeps the run brief, still above the device's pin sync delay
  hsp_host #(.QTR(8)) u_hsp_host (.clock(clock), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_bytes(cmd_bytes),
    .cmd_wdata(cmd_wdata), .sel_spi(sel_spi), .done(done), .nack_err(nack_err),
    .rdata(rdata), .irq_fall(irq_fall), .lnk(lnk));
  hsp_chk u_hsp_chk (.clock(clock), .srst(srst), .scl(lnk.scl), .ss(lnk.ss),
    .sda_h_o(lnk.sda_h_o), .sda_h_oe_n(lnk.sda_h_oe_n), .sda_d_o(lnk.sda_d_o),
    .sda_d_oe_n(lnk.sda_d_oe_n), .irq_n(lnk.irq_n), .sda(lnk.sda));
  // 40 MHz clock
  always #12.5 clock = ~clock;
  // ****************
  // helpers
  // ****************
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, well above the roughly 45k cycles the tests need
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // falls of the interrupt line seen by the host; read off the launching edge
  always @(negedge clock)
  begin
    if (irq_fall === 1'b1)
      n_fall <= n_fall + 1;
  end
  function automatic logic [31:0] fit(input logic [31:0] v, input logic [2:0] n);
    return (n == 3'h4) ? v : v & ((32'h1 << (8 * n)) - 32'h1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held from a falling edge until the rising edge that takes it
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [2:0] n,
    input logic [31:0] wd);
    @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    cmd_read = rd;
    cmd_addr = a;
    cmd_bytes = n;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(negedge clock);
  endtask
  task automatic rd(input logic [15:0] a, input logic [2:0] n, input logic [31:0] e,
    input string nm);
    xfer(1'b1, a, n, 32'h00000000);
    chk(nm, fit(e, n), rdata);
  endtask
  task automatic rst(input logic keep_npm, input logic pd);
    @(negedge clock);
    srst = 1'b1;
    npm = keep_npm;
    pdn = pd;
    repeat (12) @(negedge clock);
    srst = 1'b0;
    npm = 1'b1;
    pdn = 1'b0;
    repeat (10) @(negedge clock);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    repeat (6) @(negedge clock);
    while (cmd_ready !== 1'b1) @(negedge clock);
    repeat (10) @(negedge clock);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    m = $urandom(12927);
    rst(1'b1, 1'b0);
    chk("spi_mode", 32'h0, 32'(spi_mode));
    chk("hsc_enable", 32'h0, 32'(hsc_enable));
    for (int i = 0; i < 2; i++)
    begin
      k = $urandom_range(31);
      m = $urandom | (32'h1 << k);
      xfer(1'b0, A_MASK, 3'h4, m);
      rd(A_LAST_OPERATION_KIND, 3'h1, 32'(OP_WRITE), "last_operation_kind");
      rd(A_LAST_ADDR, 3'h2, 32'(A_MASK), "last_addr");
      rd(A_LAST_D32, 3'h4, m, "last_d32");
      rd(A_MASK, 3'h4, m, "mask");
      rd(A_LAST_OPERATION_KIND, 3'h1, 32'(OP_READ), "last_operation_kind");
    end
    cmd_wdata = $urandom;
    xfer(1'b0, A_LAST_D16, 3'h2, fit(cmd_wdata, 3'h2));
    rd(A_LAST_D16, 3'h2, cmd_wdata, "last_d16");
    xfer(1'b0, A_CFG2, 3'h1, 32'h00000001);
    chk("hsc_enable", 32'h1, 32'(hsc_enable));
    rd(A_LAST_D8, 3'h1, 32'h00000001, "last_d8");
    // a write shorter than its register is no success
    xfer(1'b0, A_MASK, 3'h1, 32'h000000A5);
    rd(A_LAST_ADDR, 3'h2, 32'(A_CFG2), "last_addr");
    // one event on a bit the mask enables
    @(negedge clock);
    event_in = 32'h1 << k;
    @(negedge clock);
    event_in = 32'h00000000;
    repeat (4) @(negedge clock);
    chk("irq_n", 32'h0, 32'(lnk.irq_n));
    rd(A_FLAG, 3'h4, 32'h1 << k, "flag");
    rd(A_LAST_ADDR, 3'h2, 32'(A_FLAG), "last_addr");
    xfer(1'b0, A_FLAG, 3'h4, 32'h00000000);
    chk("irq_n", 32'h0, 32'(lnk.irq_n));
    xfer(1'b0, A_FLAG, 3'h4, 32'h1 << k);
    repeat (4) @(negedge clock);
    chk("irq_n", 32'h1, 32'(lnk.irq_n));
    chk("irq_fall", 32'h1, 32'(n_fall));
    // four-wire choice, its lock, and what survives which reset
    rst(1'b1, 1'b0);
    chk("hsc_enable", 32'h0, 32'(hsc_enable));
    xfer(1'b0, A_CFG2, 3'h1, 32'h00000001);
    pulse(sel_spi);
    chk("spi_mode", 32'h1, 32'(spi_mode));
    chk("hsc_enable", 32'h0, 32'(hsc_enable));
    xfer(1'b1, A_LAST_OPERATION_KIND, 3'h1, 32'h00000000);
    chk("nack_err", 32'h1, 32'(nack_err));
    pulse(cfg_wr);
    chk("port_locked", 32'h1, 32'(port_locked));
    rst(1'b0, 1'b0);
    chk("spi_mode", 32'h1, 32'(spi_mode));
    rst(1'b1, 1'b1);
    chk("spi_mode", 32'h0, 32'(spi_mode));
    xfer(1'b0, A_CFG2, 3'h1, 32'h00000002);
    chk("port_locked", 32'h1, 32'(port_locked));
    pulse(sel_spi);
    chk("spi_mode", 32'h0, 32'(spi_mode));
    rst(1'b0, 1'b0);
    chk("port_locked", 32'h1, 32'(port_locked));
    rst(1'b1, 1'b0);
    chk("port_locked", 32'h0, 32'(port_locked));
    print_verdict();
  end
endmodule
`default_nettype wire
